// ===== rtl/isvu_pkg.sv
// constants, field positions and types shared by the interrupt source/vector unit
// assumes a 20-bit code address space and little-endian 32-bit vector words
package isvu_pkg;
   // address, data, trap number and level widths
   localparam int AW = 20;
   localparam int DW = 32;
   localparam int NW = 6;
   localparam int LW = 3;

   // fixed vector table entries, 4 bytes each, reset entry last
   localparam logic [19:0] FIXVEC_BASE = 20'hFFFDC;
   localparam logic [19:0] FIXVEC_ILLEGAL = 20'hFFFDC;
   localparam logic [19:0] FIXVEC_OVF = 20'hFFFE0;
   localparam logic [19:0] FIXVEC_BRK = 20'hFFFE4;
   localparam logic [19:0] FIXVEC_AMATCH = 20'hFFFE8;
   localparam logic [19:0] FIXVEC_SSTEP = 20'hFFFEC;
   localparam logic [19:0] FIXVEC_WDT = 20'hFFFF0;
   localparam logic [19:0] FIXVEC_DBC = 20'hFFFF4;
   localparam logic [19:0] FIXVEC_NMI = 20'hFFFF8;
   localparam logic [19:0] FIXVEC_RESET = 20'hFFFFC;
   localparam logic [7:0] BRK_RELOC_MARK = 8'hFF;
   localparam logic [19:0] INTB_RESET = 20'h00000;

   // trap number ranges
   localparam logic [5:0] SWNUM_ISP_LAST = 6'h1F;
   localparam logic [5:0] SWNUM_BRK = 6'h00;

   // pending source indexes, lowest index wins; also the status bit layout
   localparam int NSRC = 10;
   localparam int SRC_ILL = 0;
   localparam int SRC_OVF = 1;
   localparam int SRC_BRK = 2;
   localparam int SRC_SW = 3;
   localparam int SRC_NMI = 4;
   localparam int SRC_DBC = 5;
   localparam int SRC_WDT = 6;
   localparam int SRC_SSTEP = 7;
   localparam int SRC_AMATCH = 8;
   localparam int SRC_PER = 9;

   // apb register byte offsets
   localparam logic [7:0] OFS_MATCH0 = 8'h00;
   localparam logic [7:0] OFS_MATCH1 = 8'h04;
   localparam logic [7:0] OFS_MATCH_EN = 8'h08;
   localparam logic [7:0] OFS_INTB = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_MASK = 8'h14;
   localparam logic [7:0] OFS_LAST = 8'h18;

   // match enable bit positions and register reset values
   localparam int MEN_0 = 0;
   localparam int MEN_1 = 1;
   localparam logic [19:0] MATCH_RESET = 20'h00000;
   localparam logic [1:0] MEN_RESET = 2'h0;
   localparam logic [9:0] STATUS_RESET = 10'h000;
   localparam logic [9:0] MASK_RESET = 10'h000;

   // last-accepted register field positions
   localparam int LAST_ADDR_LSB = 0;
   localparam int LAST_KIND_LSB = 20;
   localparam int LAST_NUM_LSB = 24;

   // accepted source kinds
   typedef enum logic [3:0] {
      K_NONE, K_RESET, K_ILLEGAL, K_OVF, K_BRK, K_SWINT,
      K_NMI, K_DBC, K_WDT, K_SSTEP, K_AMATCH, K_PERIPH
   } isvu_kind_e;
endpackage

// ===== rtl/isvu_src_if.sv
// carrier between the unit's sequencer and its source classifier
// assumes both ends sit in the same clock domain
`timescale 1ns/1ps
interface isvu_src_if;
   logic [isvu_pkg::NSRC-1:0] pend;
   logic iflag;
   logic [isvu_pkg::LW-1:0] ipl;
   logic [isvu_pkg::LW-1:0] per_lvl;
   logic [isvu_pkg::NW-1:0] per_num;
   logic [isvu_pkg::NW-1:0] sw_num;
   logic sel_valid;
   logic [isvu_pkg::NSRC-1:0] sel_onehot;
   isvu_pkg::isvu_kind_e sel_kind;
   logic [isvu_pkg::AW-1:0] sel_fixed;
   logic sel_reloc;
   logic [isvu_pkg::NW-1:0] sel_num;

   modport seq (output pend, iflag, ipl, per_lvl, per_num, sw_num,
      input sel_valid, sel_onehot, sel_kind, sel_fixed, sel_reloc, sel_num);
   modport cls (input pend, iflag, ipl, per_lvl, per_num, sw_num,
      output sel_valid, sel_onehot, sel_kind, sel_fixed, sel_reloc, sel_num);
endinterface

// ===== rtl/isvu_classify.sv
// source classifier: picks the winning pending source and its vector
// assumes pending bits other than the live peripheral request are already latched; purely combinational
`timescale 1ns/1ps
module isvu_classify (
   isvu_src_if.cls s
);
   // source index to kind
   function automatic isvu_pkg::isvu_kind_e src_kind(input int idx);
      case (idx)
         isvu_pkg::SRC_ILL: src_kind = isvu_pkg::K_ILLEGAL;
         isvu_pkg::SRC_OVF: src_kind = isvu_pkg::K_OVF;
         isvu_pkg::SRC_BRK: src_kind = isvu_pkg::K_BRK;
         isvu_pkg::SRC_SW: src_kind = isvu_pkg::K_SWINT;
         isvu_pkg::SRC_NMI: src_kind = isvu_pkg::K_NMI;
         isvu_pkg::SRC_DBC: src_kind = isvu_pkg::K_DBC;
         isvu_pkg::SRC_WDT: src_kind = isvu_pkg::K_WDT;
         isvu_pkg::SRC_SSTEP: src_kind = isvu_pkg::K_SSTEP;
         isvu_pkg::SRC_AMATCH: src_kind = isvu_pkg::K_AMATCH;
         isvu_pkg::SRC_PER: src_kind = isvu_pkg::K_PERIPH;
         default: src_kind = isvu_pkg::K_NONE;
      endcase
   endfunction

   // kind to fixed vector entry
   function automatic logic [19:0] fixed_vec(input isvu_pkg::isvu_kind_e k);
      case (k)
         isvu_pkg::K_ILLEGAL: fixed_vec = isvu_pkg::FIXVEC_ILLEGAL; // RULE2
         isvu_pkg::K_OVF: fixed_vec = isvu_pkg::FIXVEC_OVF; // RULE3
         isvu_pkg::K_BRK: fixed_vec = isvu_pkg::FIXVEC_BRK; // RULE4
         isvu_pkg::K_NMI: fixed_vec = isvu_pkg::FIXVEC_NMI; // RULE10
         isvu_pkg::K_DBC: fixed_vec = isvu_pkg::FIXVEC_DBC;
         isvu_pkg::K_WDT: fixed_vec = isvu_pkg::FIXVEC_WDT; // RULE11
         isvu_pkg::K_SSTEP: fixed_vec = isvu_pkg::FIXVEC_SSTEP;
         isvu_pkg::K_AMATCH: fixed_vec = isvu_pkg::FIXVEC_AMATCH; // RULE12
         default: fixed_vec = isvu_pkg::FIXVEC_RESET;
      endcase
   endfunction

   logic [isvu_pkg::NSRC-1:0] elig;
   logic per_ok;

   // peripheral requests obey the global enable and the level compare
   assign per_ok = s.iflag && (s.per_lvl > s.ipl); // RULE14
   always_comb begin
      elig = s.pend;
      elig[isvu_pkg::SRC_PER] = s.pend[isvu_pkg::SRC_PER] && per_ok; // RULE14
   end

   // lowest index wins; only peripherals see the enable flag
   always_comb begin
      s.sel_valid = 1'b0;
      s.sel_onehot = '0;
      s.sel_kind = isvu_pkg::K_NONE;
      for (int i = isvu_pkg::NSRC - 1; i >= 0; i--) begin
         if (elig[i]) begin // RULE1 RULE9
            s.sel_valid = 1'b1;
            s.sel_onehot = '0;
            s.sel_onehot[i] = 1'b1;
            s.sel_kind = src_kind(i);
         end
      end
   end

   // vector source: relocatable table for trap numbers and peripherals
   always_comb begin
      s.sel_fixed = fixed_vec(s.sel_kind);
      s.sel_reloc = (s.sel_kind == isvu_pkg::K_SWINT) || (s.sel_kind == isvu_pkg::K_PERIPH);
      case (s.sel_kind)
         isvu_pkg::K_SWINT: s.sel_num = s.sw_num; // RULE5
         isvu_pkg::K_PERIPH: s.sel_num = s.per_num; // RULE6
         default: s.sel_num = isvu_pkg::SWNUM_BRK;
      endcase
   end
endmodule

// ===== rtl/isvu_top.sv
// interrupt source classification and vector fetch sequencer
// assumes the core gives one-cycle trap pulses and a word read port for vectors
//
// Functional notes
// RULE1: instruction traps ignore the enable flag and levels.
// RULE2: illegal opcodes always trap via the lowest fixed entry.
// RULE3: the trap-on-overflow instruction traps only when the overflow flag is one.
// RULE4: breakpoint traps, and uses relocatable entry 0 when its vector top byte is all ones.
// RULE5: software traps 0 to 63 vector via the relocatable table.
// RULE6: trap numbers 4 to 31 share their entries with the peripheral sources.
// RULE7: numbers 0 to 31 push the stack-select flag and clear it; return restores it.
// RULE8: numbers 32 to 63 leave the stack-select flag alone.
// RULE9: watchdog, pin, debugger, clock-stop, low-voltage, step and match are unmaskable.
// RULE10: the non-maskable pin fires on a high-to-low change and uses its own entry.
// RULE11: watchdog, clock-stop and low-voltage share one entry; software reloads the watchdog.
// RULE12: an enabled match register equal to the next address raises a match trap.
// RULE13: software leaves the step and debugger entries to development tools.
// RULE14: peripherals need the enable flag and a level above the current one.
// RULE15: each entry is a four-byte handler address that is branched to.
// RULE16: the fixed table runs from its base to the top; reset is last.
// RULE17: the image keeps the low nibble of the top vector byte at all ones.
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module isvu_top (
   input wire logic I_CLK,
   input wire logic I_RST,
   // apb slave
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [7:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   output logic [31:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   // instruction traps from the core
   input wire logic I_ILLEGAL_OPCODE_INSTR,
   input wire logic I_OVF_INSTR,
   input wire logic I_OVF_FLAG,
   input wire logic I_BREAKPOINT_INSTR,
   input wire logic I_SWTRAP_INSTR,
   input wire logic [5:0] I_SWTRAP_NUM,
   // special hardware sources
   input wire logic I_NMI_N,
   input wire logic I_DEBUGGER_IRQ,
   input wire logic I_WDT_IRQ,
   input wire logic I_OSC_STOP_IRQ,
   input wire logic I_LOW_VOLT_IRQ,
   input wire logic I_SINGLE_STEP_IRQ,
   // next instruction address for the match compare
   input wire logic I_INSN_VALID,
   input wire logic [19:0] I_INSN_ADDR,
   // peripheral request and the core's enable state
   input wire logic I_PER_REQ,
   input wire logic [5:0] I_PER_NUM,
   input wire logic [2:0] I_PER_LVL,
   input wire logic I_IFLAG,
   input wire logic [2:0] I_IPL,
   output logic O_PER_ACK,
   // vector read port
   output logic O_VEC_RD,
   output logic [19:0] O_VEC_ADDR,
   input wire logic I_VEC_ACK,
   input wire logic [31:0] I_VEC_DATA,
   // branch to the handler
   output logic O_TRAP_PENDING,
   output logic O_BRANCH,
   output logic [19:0] O_BRANCH_ADDR,
   output logic O_PUSH_STACK_SEL,
   output logic O_IRQ
);
   typedef enum logic [1:0] {S_IDLE, S_FETCH, S_BRANCH} isvu_state_e;

   isvu_src_if src();

   isvu_state_e state_q, state_d;
   logic [19:0] match_addr_0_q, match_addr_1_q;
   logic [1:0] match_enable_reg_q;
   logic [19:0] intb_q;
   logic [9:0] status_q, mask_q;
   logic [9:0] pend_q;
   logic nmi_prev_q;
   logic [19:0] vaddr_q;
   logic brk_reloc_q;
   isvu_pkg::isvu_kind_e kind_q;
   logic [5:0] num_q;
   logic [19:0] branch_addr_q;
   logic branch_q, push_q, per_ack_q;
   logic [31:0] last_q;
   logic [31:0] prdata_q;
   logic take, ack_now, reloc_brk;
   logic [9:0] set_ev, clr_w1c;
   logic nmi_edge, amatch;
   logic setup_ph, wr_acc;

   // register decode; also flags unmapped offsets
   function automatic logic [2:0] reg_sel(input logic [7:0] a);
      case (a)
         isvu_pkg::OFS_MATCH0: reg_sel = 3'h0;
         isvu_pkg::OFS_MATCH1: reg_sel = 3'h1;
         isvu_pkg::OFS_MATCH_EN: reg_sel = 3'h2;
         isvu_pkg::OFS_INTB: reg_sel = 3'h3;
         isvu_pkg::OFS_STATUS: reg_sel = 3'h4;
         isvu_pkg::OFS_MASK: reg_sel = 3'h5;
         isvu_pkg::OFS_LAST: reg_sel = 3'h6;
         default: reg_sel = 3'h7;
      endcase
   endfunction

   // apb phases: zero wait, read data captured during setup
   assign setup_ph = I_PSEL && !I_PENABLE;
   assign wr_acc = I_PSEL && I_PENABLE && I_PWRITE && (reg_sel(I_PADDR) != 3'h7);
   assign O_PREADY = 1'b1;
   assign O_PSLVERR = I_PSEL && I_PENABLE && (reg_sel(I_PADDR) == 3'h7);
   assign O_PRDATA = prdata_q;

   // read data register
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         prdata_q <= 32'h00000000;
      end else if (setup_ph && !I_PWRITE) begin
         case (reg_sel(I_PADDR))
            3'h0: prdata_q <= {12'h000, match_addr_0_q};
            3'h1: prdata_q <= {12'h000, match_addr_1_q};
            3'h2: prdata_q <= {30'h00000000, match_enable_reg_q};
            3'h3: prdata_q <= {12'h000, intb_q};
            3'h4: prdata_q <= {22'h000000, status_q};
            3'h5: prdata_q <= {22'h000000, mask_q};
            3'h6: prdata_q <= last_q;
            default: prdata_q <= 32'h00000000;
         endcase
      end
   end

   // software configuration registers
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         match_addr_0_q <= isvu_pkg::MATCH_RESET;
         match_addr_1_q <= isvu_pkg::MATCH_RESET;
         match_enable_reg_q <= isvu_pkg::MEN_RESET;
         intb_q <= isvu_pkg::INTB_RESET;
         mask_q <= isvu_pkg::MASK_RESET;
      end else if (wr_acc) begin
         case (reg_sel(I_PADDR))
            3'h0: match_addr_0_q <= I_PWDATA[19:0];
            3'h1: match_addr_1_q <= I_PWDATA[19:0];
            3'h2: match_enable_reg_q <= I_PWDATA[1:0];
            3'h3: intb_q <= I_PWDATA[19:0];
            3'h5: mask_q <= I_PWDATA[9:0];
            default: ;
         endcase
      end
   end

   // sticky status, write one to clear, set wins
   assign clr_w1c = (wr_acc && reg_sel(I_PADDR) == 3'h4) ? I_PWDATA[9:0] : 10'h000;
   assign set_ev = take ? src.sel_onehot : 10'h000;
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         status_q <= isvu_pkg::STATUS_RESET;
      end else begin
         status_q <= (status_q & ~clr_w1c) | set_ev;
      end
   end
   assign O_IRQ = |(status_q & mask_q);

   // falling edge of the non-maskable pin
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         nmi_prev_q <= 1'b1;
      end else begin
         nmi_prev_q <= I_NMI_N;
      end
   end
   assign nmi_edge = nmi_prev_q && !I_NMI_N; // RULE10

   // address compare, per enable bit
   assign amatch = I_INSN_VALID &&
      ((match_enable_reg_q[isvu_pkg::MEN_0] && I_INSN_ADDR == match_addr_0_q) ||
       (match_enable_reg_q[isvu_pkg::MEN_1] && I_INSN_ADDR == match_addr_1_q)); // RULE12

   // pending sources, cleared when accepted; a new event wins
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         pend_q <= 10'h000;
      end else begin
         pend_q[isvu_pkg::SRC_ILL] <= (pend_q[isvu_pkg::SRC_ILL]
            && !set_ev[isvu_pkg::SRC_ILL]) || I_ILLEGAL_OPCODE_INSTR; // RULE2
         pend_q[isvu_pkg::SRC_OVF] <= (pend_q[isvu_pkg::SRC_OVF]
            && !set_ev[isvu_pkg::SRC_OVF]) || (I_OVF_INSTR && I_OVF_FLAG); // RULE3
         pend_q[isvu_pkg::SRC_BRK] <= (pend_q[isvu_pkg::SRC_BRK]
            && !set_ev[isvu_pkg::SRC_BRK]) || I_BREAKPOINT_INSTR; // RULE4
         pend_q[isvu_pkg::SRC_SW] <= (pend_q[isvu_pkg::SRC_SW]
            && !set_ev[isvu_pkg::SRC_SW]) || I_SWTRAP_INSTR; // RULE5
         pend_q[isvu_pkg::SRC_NMI] <= (pend_q[isvu_pkg::SRC_NMI]
            && !set_ev[isvu_pkg::SRC_NMI]) || nmi_edge; // RULE10
         pend_q[isvu_pkg::SRC_DBC] <= (pend_q[isvu_pkg::SRC_DBC]
            && !set_ev[isvu_pkg::SRC_DBC]) || I_DEBUGGER_IRQ; // RULE9
         pend_q[isvu_pkg::SRC_WDT] <= (pend_q[isvu_pkg::SRC_WDT]
            && !set_ev[isvu_pkg::SRC_WDT])
            || I_WDT_IRQ || I_OSC_STOP_IRQ || I_LOW_VOLT_IRQ; // RULE11
         pend_q[isvu_pkg::SRC_SSTEP] <= (pend_q[isvu_pkg::SRC_SSTEP]
            && !set_ev[isvu_pkg::SRC_SSTEP]) || I_SINGLE_STEP_IRQ; // RULE9
         pend_q[isvu_pkg::SRC_AMATCH] <= (pend_q[isvu_pkg::SRC_AMATCH]
            && !set_ev[isvu_pkg::SRC_AMATCH]) || amatch; // RULE12
         pend_q[isvu_pkg::SRC_PER] <= 1'b0;
      end
   end

   // trap number captured with the instruction
   logic [5:0] sw_num_q;
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         sw_num_q <= 6'h00;
      end else if (I_SWTRAP_INSTR) begin
         sw_num_q <= I_SWTRAP_NUM; // RULE5
      end
   end

   // classifier hookup; the peripheral request is a live level
   always_comb begin
      src.pend = pend_q;
      src.pend[isvu_pkg::SRC_PER] = I_PER_REQ; // RULE14
   end
   assign src.iflag = I_IFLAG;
   assign src.ipl = I_IPL;
   assign src.per_lvl = I_PER_LVL;
   assign src.per_num = I_PER_NUM;
   assign src.sw_num = sw_num_q;

   isvu_classify u_cls (
      .s(src.cls)
   );

   assign O_TRAP_PENDING = src.sel_valid;
   assign take = (state_q == S_IDLE) && src.sel_valid;
   assign ack_now = (state_q == S_FETCH) && I_VEC_ACK;
   assign reloc_brk = (kind_q == isvu_pkg::K_BRK) && !brk_reloc_q
      && (I_VEC_DATA[31:24] == isvu_pkg::BRK_RELOC_MARK); // RULE4

   // sequencer: reset vector, then one source at a time
   always_comb begin
      state_d = state_q;
      case (state_q)
         S_IDLE: begin
            if (take) begin
               state_d = S_FETCH;
            end
         end
         S_FETCH: begin
            if (ack_now && !reloc_brk) begin
               state_d = S_BRANCH;
            end
         end
         S_BRANCH: state_d = S_IDLE;
         default: state_d = S_IDLE;
      endcase
   end

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         state_q <= S_FETCH;
      end else begin
         state_q <= state_d;
      end
   end

   // vector address and the accepted source
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         vaddr_q <= isvu_pkg::FIXVEC_RESET; // RULE16
         kind_q <= isvu_pkg::K_RESET;
         num_q <= 6'h00;
         brk_reloc_q <= 1'b0;
      end else if (take) begin
         kind_q <= src.sel_kind;
         num_q <= src.sel_num;
         brk_reloc_q <= 1'b0;
         if (src.sel_reloc) begin
            vaddr_q <= intb_q + {12'h000, src.sel_num, 2'b00}; // RULE5 RULE6 RULE15
         end else begin
            vaddr_q <= src.sel_fixed; // RULE1 RULE16
         end
      end else if (ack_now && reloc_brk) begin
         vaddr_q <= intb_q + {12'h000, isvu_pkg::SWNUM_BRK, 2'b00}; // RULE4
         brk_reloc_q <= 1'b1;
      end
   end
   assign O_VEC_RD = (state_q == S_FETCH);
   assign O_VEC_ADDR = vaddr_q;

   // branch pulse, handler address and stack-select push
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         branch_q <= 1'b0;
         push_q <= 1'b0;
         branch_addr_q <= 20'h00000;
      end else begin
         branch_q <= ack_now && !reloc_brk; // RULE15
         push_q <= ack_now && !reloc_brk && (kind_q != isvu_pkg::K_RESET)
            && !(kind_q == isvu_pkg::K_SWINT && num_q > isvu_pkg::SWNUM_ISP_LAST); // RULE7 RULE8
         if (ack_now && !reloc_brk) begin
            branch_addr_q <= I_VEC_DATA[19:0]; // RULE15
         end
      end
   end
   assign O_BRANCH = branch_q;
   assign O_BRANCH_ADDR = branch_addr_q;
   assign O_PUSH_STACK_SEL = push_q;

   // peripheral acknowledge and last accepted source record
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         per_ack_q <= 1'b0;
         last_q <= 32'h00000000;
      end else begin
         per_ack_q <= take && src.sel_onehot[isvu_pkg::SRC_PER];
         if (ack_now && !reloc_brk) begin
            last_q[isvu_pkg::LAST_ADDR_LSB +: 20] <= vaddr_q;
            last_q[isvu_pkg::LAST_KIND_LSB +: 4] <= kind_q;
            last_q[isvu_pkg::LAST_NUM_LSB +: 6] <= num_q;
         end
      end
   end
   assign O_PER_ACK = per_ack_q;
endmodule

// ===== verification/isvu_asserts.sv
// port checker for the interrupt source/vector unit
// assumes one clock domain; bound to the top module below
`timescale 1ns/1ps
module isvu_asserts (
   input wire logic I_CLK,
   input wire logic I_RST,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic [7:0] I_PADDR,
   input wire logic [31:0] O_PRDATA,
   input wire logic O_PSLVERR,
   input wire logic I_ILLEGAL_OPCODE_INSTR,
   input wire logic I_OVF_INSTR,
   input wire logic I_OVF_FLAG,
   input wire logic I_NMI_N,
   input wire logic I_PER_REQ,
   input wire logic [2:0] I_PER_LVL,
   input wire logic I_IFLAG,
   input wire logic [2:0] I_IPL,
   input wire logic O_PER_ACK,
   input wire logic O_VEC_RD,
   input wire logic [19:0] O_VEC_ADDR,
   input wire logic I_VEC_ACK,
   input wire logic [31:0] I_VEC_DATA,
   input wire logic O_TRAP_PENDING,
   input wire logic O_BRANCH,
   input wire logic [19:0] O_BRANCH_ADDR,
   input wire logic O_PUSH_STACK_SEL
);
   default clocking @(posedge I_CLK); endclocking
   default disable iff (I_RST);
   // trap sources become pending at once, whatever the enable state
   ill_pend_a: assert property (I_ILLEGAL_OPCODE_INSTR |=> O_TRAP_PENDING)
      else $error("ill trap late");
   ovf_pend_a: assert property (I_OVF_INSTR && I_OVF_FLAG |=> O_TRAP_PENDING)
      else $error("ovf trap late");
   nmi_edge_a: assert property ($fell(I_NMI_N) |-> ##[1:3] O_TRAP_PENDING)
      else $error("pin edge lost");
   // vector reads and the branch that follows them, then peripheral acknowledge and unmapped offsets
   rd_hold_a: assert property (O_VEC_RD && !I_VEC_ACK |=> O_VEC_RD && $stable(O_VEC_ADDR))
      else $error("read dropped");
   branch_data_a: assert property (O_BRANCH |-> $past(I_VEC_ACK) && O_BRANCH_ADDR == $past(I_VEC_DATA[19:0]))
      else $error("bad branch addr");
   brk_reloc_a: assert property (O_VEC_RD && I_VEC_ACK && O_VEC_ADDR == isvu_pkg::FIXVEC_BRK
      && I_VEC_DATA[31:24] == isvu_pkg::BRK_RELOC_MARK |=> !O_BRANCH ##[0:2] O_VEC_RD)
      else $error("no second read");
   vec_align_a: assert property (O_VEC_RD |-> O_VEC_ADDR[1:0] == 2'h0)
      else $error("vec unaligned");
   push_with_a: assert property (O_PUSH_STACK_SEL |-> O_BRANCH)
      else $error("lone push");
   per_ack_a: assert property (O_PER_ACK |-> $past(I_PER_REQ && I_IFLAG && I_PER_LVL > I_IPL))
      else $error("bad per ack");
   slverr_a: assert property (I_PSEL && I_PENABLE && I_PADDR > isvu_pkg::OFS_LAST
      |-> O_PSLVERR && O_PRDATA == 32'h0)
      else $error("unmapped not refused");
endmodule
bind isvu_top isvu_asserts chk_u (.*);

// ===== verification/isvu_vec_mem.sv
// vector memory model: answers each word read after a chosen delay
// assumes the unit holds a read until it is acknowledged
`timescale 1ns/1ps
module isvu_vec_mem (
   input wire logic clk,
   input wire logic rst,
   input wire logic rd,
   input wire logic [19:0] addr,
   input wire logic brk_reloc,
   input wire logic [1:0] slow,
   output logic ack,
   output logic [31:0] data
);
   logic [1:0] wait_q;
   logic [7:0] top;
   // top byte keeps its reserved low nibble at ones
   assign top = (brk_reloc && addr == isvu_pkg::FIXVEC_BRK) ? 8'hFF : 8'h0F;
   // wait, acknowledge once, then scramble the idle bus
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ack <= 1'b0;
         data <= 32'h0;
         wait_q <= 2'h0;
      end else if (rd && !ack && wait_q == slow) begin
         ack <= 1'b1;
         data <= {top, 4'h0, addr ^ 20'h0A5A5};
         wait_q <= 2'h0;
      end else begin
         ack <= 1'b0;
         data <= ~data;
         wait_q <= (rd && !ack) ? wait_q + 2'h1 : 2'h0;
      end
   end
endmodule

// ===== verification/testbench.sv
// self-checking bench for the interrupt source/vector unit
// assumes the memory model answers every vector read
`timescale 1ns/1ps
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin num_errors++; \
   $display("mismatch %s expected %h seen %h", nm, e, s); end end
module testbench;
   logic I_CLK, I_RST, I_PSEL, I_PENABLE, I_PWRITE, I_ILLEGAL_OPCODE_INSTR, I_OVF_INSTR;
   logic I_OVF_FLAG, I_BREAKPOINT_INSTR, I_SWTRAP_INSTR, I_NMI_N, I_DEBUGGER_IRQ, I_WDT_IRQ;
   logic I_OSC_STOP_IRQ, I_LOW_VOLT_IRQ, I_SINGLE_STEP_IRQ, I_INSN_VALID, I_PER_REQ, I_IFLAG;
   logic O_PREADY, O_PSLVERR, O_PER_ACK, O_VEC_RD, I_VEC_ACK, O_TRAP_PENDING, O_BRANCH;
   logic O_PUSH_STACK_SEL, O_IRQ, reloc, er;
   logic [7:0] I_PADDR;
   logic [31:0] I_PWDATA, O_PRDATA, I_VEC_DATA, rd;
   logic [5:0] I_SWTRAP_NUM, I_PER_NUM;
   logic [2:0] I_PER_LVL, I_IPL;
   logic [19:0] I_INSN_ADDR, O_VEC_ADDR, O_BRANCH_ADDR, ib, ma;
   logic [1:0] slow;
   logic [15:0] rnd = 16'h0032;
   logic [20:0] vexp[$];
   logic [20:0] nt;
   logic [5:0] sw[6] = '{6'h00, 6'h04, 6'h0F, 6'h1F, 6'h20, 6'h3F};
   int num_errors = 0;
   int checked = 0;
   isvu_top dut_u (.*);
   isvu_vec_mem mem_u (.clk(I_CLK), .rst(I_RST), .rd(O_VEC_RD), .addr(O_VEC_ADDR),
      .brk_reloc(reloc), .slow(slow), .ack(I_VEC_ACK), .data(I_VEC_DATA));
   // clock
   initial begin
      I_CLK = 1'b0;
      forever #2.5 I_CLK = ~I_CLK;
   end
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic wrap_up;
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // one apb transfer
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int t;
      I_PSEL <= 1'b1;
      I_PWRITE <= w;
      I_PADDR <= a;
      I_PWDATA <= d;
      @(posedge I_CLK);
      I_PENABLE <= 1'b1;
      t = 0;
      do begin
         @(posedge I_CLK);
         t++;
      end while (O_PREADY !== 1'b1 && t < 20);
      if (t == 20) begin num_errors++; wrap_up(); end
      rd = O_PRDATA;
      er = O_PSLVERR;
      I_PSEL <= 1'b0;
      I_PENABLE <= 1'b0;
      @(posedge I_CLK);
   endtask
   // raise a source, note its branch, wait
   task automatic hit(input int k, input logic [5:0] n, input logic want);
      int t;
      logic [19:0] va;
      case (k)
         0: va = isvu_pkg::FIXVEC_ILLEGAL;
         1: va = isvu_pkg::FIXVEC_OVF;
         2: va = reloc ? ib : isvu_pkg::FIXVEC_BRK;
         4: va = isvu_pkg::FIXVEC_NMI;
         5: va = isvu_pkg::FIXVEC_DBC;
         6, 7, 8: va = isvu_pkg::FIXVEC_WDT;
         9: va = isvu_pkg::FIXVEC_SSTEP;
         10: va = isvu_pkg::FIXVEC_AMATCH;
         3, 11: va = ib + {12'h000, n, 2'h0};
         default: va = isvu_pkg::FIXVEC_RESET;
      endcase
      if (want)
         vexp.push_back({k < 12 && (k != 3 || n < 6'h20), va ^ 20'h0A5A5});
      {I_OVF_FLAG, I_IFLAG} <= {2{want}};
      {I_SWTRAP_NUM, I_PER_NUM} <= {2{n}};
      I_INSN_ADDR <= want ? ma : ma + 20'h4;
      case (k)
         0: I_ILLEGAL_OPCODE_INSTR <= 1'b1;
         1: I_OVF_INSTR <= 1'b1;
         2: I_BREAKPOINT_INSTR <= 1'b1;
         3: I_SWTRAP_INSTR <= 1'b1;
         4: I_NMI_N <= 1'b0;
         5: I_DEBUGGER_IRQ <= 1'b1;
         6: I_WDT_IRQ <= 1'b1;
         7: I_OSC_STOP_IRQ <= 1'b1;
         8: I_LOW_VOLT_IRQ <= 1'b1;
         9: I_SINGLE_STEP_IRQ <= 1'b1;
         10: I_INSN_VALID <= 1'b1;
         11: I_PER_REQ <= 1'b1;
         default: ;
      endcase
      @(posedge I_CLK);
      {I_ILLEGAL_OPCODE_INSTR, I_OVF_INSTR, I_BREAKPOINT_INSTR, I_SWTRAP_INSTR} <= 4'h0;
      {I_DEBUGGER_IRQ, I_WDT_IRQ, I_OSC_STOP_IRQ, I_LOW_VOLT_IRQ} <= 4'h0;
      {I_SINGLE_STEP_IRQ, I_INSN_VALID, I_PER_REQ, I_NMI_N} <= 4'h1;
      for (t = 0; t < 40 && (vexp.size() != 0 || t < 4); t++)
         @(posedge I_CLK);
      `CHK("trap pending", 1'b0, O_TRAP_PENDING)
      if (vexp.size() != 0) begin num_errors++; wrap_up(); end
      @(posedge I_CLK);
   endtask
   // check branches against the notes
   always @(negedge I_CLK) begin
      if (O_BRANCH === 1'b1) begin
         nt = (vexp.size() != 0) ? vexp.pop_front() : 21'h1FFFFF;
         `CHK("branch", nt, {O_PUSH_STACK_SEL, O_BRANCH_ADDR})
      end
   end
   // main sequence
   initial begin
      {I_PSEL, I_PENABLE, I_PWRITE, I_ILLEGAL_OPCODE_INSTR, I_OVF_INSTR, I_OVF_FLAG} = 6'h00;
      {I_BREAKPOINT_INSTR, I_SWTRAP_INSTR, I_DEBUGGER_IRQ, I_WDT_IRQ, I_OSC_STOP_IRQ} = 5'h00;
      {I_LOW_VOLT_IRQ, I_SINGLE_STEP_IRQ, I_INSN_VALID, I_PER_REQ, I_IFLAG, reloc} = 6'h00;
      {I_NMI_N, I_RST, I_PADDR, I_PWDATA} = {2'h3, 40'h0};
      {I_SWTRAP_NUM, I_PER_NUM, I_INSN_ADDR, slow} = 34'h0;
      I_PER_LVL = 3'h5;
      I_IPL = 3'h2;
      rnd = lfsr(rnd);
      ib = {2'h0, rnd[13:0], 4'h0};
      rnd = lfsr(rnd);
      ma = {rnd, 4'h0};
      repeat (5) @(posedge I_CLK);
      I_RST <= 1'b0;
      hit(12, 6'h00, 1'b1);
      for (int a = 0; a < 6; a++) begin
         apb(1'b0, {a[5:0], 2'h0}, 32'h0);
         `CHK("reg reset", 32'h0, rd)
      end
      apb(1'b0, 8'h40, 32'h0);
      `CHK("unmapped", 33'h100000000, {er, rd})
      apb(1'b1, isvu_pkg::OFS_MATCH0, {12'h000, ma});
      apb(1'b1, isvu_pkg::OFS_MATCH1, {12'h000, ma + 20'h4});
      apb(1'b1, isvu_pkg::OFS_MATCH_EN, 32'h1);
      apb(1'b1, isvu_pkg::OFS_INTB, {12'h000, ib});
      for (int k = 0; k < 12; k++)
         hit(k, 6'(k + 4), 1'b1);
      foreach (sw[i])
         hit(3, sw[i], 1'b1);
      rnd = lfsr(rnd);
      hit(3, rnd[5:0], 1'b1);
      hit(1, 6'h00, 1'b0);
      hit(10, 6'h00, 1'b0);
      hit(11, 6'h05, 1'b0);
      reloc <= 1'b1;
      slow <= 2'h3;
      @(posedge I_CLK);
      hit(2, 6'h00, 1'b1);
      apb(1'b0, isvu_pkg::OFS_STATUS, 32'h0);
      `CHK("status", 32'h3FF, rd)
      `CHK("irq masked", 1'b0, O_IRQ)
      apb(1'b1, isvu_pkg::OFS_MASK, 32'h10);
      `CHK("irq on", 1'b1, O_IRQ)
      apb(1'b1, isvu_pkg::OFS_STATUS, 32'h3FF);
      apb(1'b0, isvu_pkg::OFS_STATUS, 32'h0);
      `CHK("status clear", 33'h0, {O_IRQ, rd})
      wrap_up();
   end
endmodule
